/* File: common/lgam_map.vh */
// address map constants for the local to global translation block
`ifndef LGAM_MAP_VH
`define LGAM_MAP_VH

// ----------------------------------------------------------------------
// ahb register offsets (byte addresses of this block's slave, plus word indexes of the part id bytes)
// ----------------------------------------------------------------------
`define LGAM_PARTID_HI_IDX   8'h1a   // part_id_high_byte index
`define LGAM_PARTID_LO_IDX   8'h1b   // part_id_low_byte index
`define LGAM_PARTID_HI_OFS   10'h068 // byte address, four times index
`define LGAM_PARTID_LO_OFS   10'h06c // byte address, four times index
`define LGAM_PROGRAM_PAGE_SELECT_OFS       10'h000 // program_page_select register
`define LGAM_XLATE_IN_OFS    10'h004 // local address to translate
`define LGAM_XLATE_OUT_OFS   10'h008 // resulting global address
`define LGAM_VERSION_OFS     10'h00c // version identifier word
`define LGAM_CFG_OFS         10'h010 // ram variant select

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define LGAM_PROGRAM_PAGE_SELECT_RST       8'h0f
`define LGAM_CFG_RST         1'b0

// ----------------------------------------------------------------------
// part id field positions
// ----------------------------------------------------------------------
`define LGAM_ID_MAJFAM_HI    15
`define LGAM_ID_MAJFAM_LO    12
`define LGAM_ID_MINFAM_HI    11
`define LGAM_ID_MINFAM_LO    6
`define LGAM_ID_MAJREV_HI    5
`define LGAM_ID_MAJREV_LO    4
`define LGAM_ID_MINREV_HI    3
`define LGAM_ID_MINREV_LO    0

// ----------------------------------------------------------------------
// local region bounds and global bases
// ----------------------------------------------------------------------
`define LGAM_DF_LO           16'h0400
`define LGAM_DF_HI           16'h13ff
`define LGAM_DF_GBASE        18'h04400
`define LGAM_RAM_LO          16'h1400
`define LGAM_RAM_HI          16'h27ff
`define LGAM_RAM_HI_4K       16'h2fff
`define LGAM_RAM_GBASE       18'h31400
`define LGAM_PF1_LO          16'h4000
`define LGAM_PF1_HI          16'h7fff
`define LGAM_PF1_GBASE       18'h34000
`define LGAM_WIN_LO          16'h8000
`define LGAM_WIN_HI          16'hbfff
`define LGAM_PF2_LO          16'hc000
`define LGAM_PF2_GBASE       18'h3c000
`define LGAM_PAGE_BITS       14

`endif

/* File: rtl/lgam_xlate.v */
// combinational local to global address translator
`timescale 1ns/10ps

module lgam_xlate (
  input  wire [15:0] local_addr,   // 64k local address
  input  wire [7:0]  program_page_select,        // program_page_select value
  input  wire        ram_4k,       // high selects the 4k ram bound
  output reg  [17:0] global_addr,  // 256k global address
  output reg  [2:0]  region        // 0 default,1 dflash,2 ram,3 pf,4 window
);
`include "lgam_map.vh"

  wire [15:0] ram_hi;  // ram bound depends on variant
  assign ram_hi = ram_4k ? `LGAM_RAM_HI_4K : `LGAM_RAM_HI;

  // ----------------------------------------------------------------------
  // region decode
  // ----------------------------------------------------------------------
  always @* begin
    global_addr = {2'b11, local_addr}; // default translation
    region      = 3'h0;
    if (local_addr >= `LGAM_DF_LO && local_addr <= `LGAM_DF_HI) begin
      // dflash one to one
      global_addr = `LGAM_DF_GBASE + {2'b00, local_addr - `LGAM_DF_LO};
      region      = 3'h1;
    end else if (local_addr >= `LGAM_RAM_LO && local_addr <= ram_hi) begin
      // ram region
      global_addr = `LGAM_RAM_GBASE + {2'b00, local_addr - `LGAM_RAM_LO};
      region      = 3'h2;
    end else if (local_addr >= `LGAM_PF1_LO && local_addr <= `LGAM_PF1_HI) begin
      // unpaged flash low
      global_addr = `LGAM_PF1_GBASE + {2'b00, local_addr - `LGAM_PF1_LO};
      region      = 3'h3;
    end else if (local_addr >= `LGAM_WIN_LO && local_addr <= `LGAM_WIN_HI) begin
      // paged window, 16k per page
      global_addr = {program_page_select[3:0], local_addr[`LGAM_PAGE_BITS-1:0]};
      region      = 3'h4;
    end else if (local_addr >= `LGAM_PF2_LO) begin
      // unpaged flash high
      global_addr = `LGAM_PF2_GBASE + {2'b00, local_addr - `LGAM_PF2_LO};
      region      = 3'h3;
    end
  end

endmodule // lgam_xlate

/* File: rtl/lgam_partid.v */
// read-only part identification assembly
`timescale 1ns/10ps

module lgam_partid #(
  parameter [3:0] MAJ_FAMILY = 4'h1,  // arbitrary value
  parameter [5:0] MIN_FAMILY = 6'h02, // arbitrary value
  parameter [1:0] MAJ_REV    = 2'h0,  // arbitrary value
  parameter [3:0] MIN_REV    = 4'h1   // arbitrary value
) (
  output wire [7:0] id_high,  // part_id_high_byte
  output wire [7:0] id_low    // part_id_low_byte
);
`include "lgam_map.vh"

  wire [15:0] part_id;  // packed identifier

  // four fields packed at fixed positions
  assign part_id[`LGAM_ID_MAJFAM_HI:`LGAM_ID_MAJFAM_LO] = MAJ_FAMILY;
  assign part_id[`LGAM_ID_MINFAM_HI:`LGAM_ID_MINFAM_LO] = MIN_FAMILY;
  assign part_id[`LGAM_ID_MAJREV_HI:`LGAM_ID_MAJREV_LO] = MAJ_REV;
  assign part_id[`LGAM_ID_MINREV_HI:`LGAM_ID_MINREV_LO] = MIN_REV;

  // fixed constant, nothing can write it
  assign id_high = part_id[15:8];
  assign id_low  = part_id[7:0];

endmodule // lgam_partid

/* File: rtl/lgam_top.v */
// ahb-lite register slave and address map of the local to global block
`timescale 1ns/10ps

module lgam_top #(
  parameter [15:0] VERSION_ID = 16'h0000  // arbitrary value
) (
  input  wire        core_clk,    // bus clock
  input  wire        rst,         // synchronous reset, active high
  input  wire        hsel,        // slave select
  input  wire [31:0] haddr,       // byte address
  input  wire [1:0]  htrans,      // transfer type
  input  wire        hwrite,      // write when high
  input  wire [2:0]  hsize,       // transfer size
  input  wire        hready,      // bus ready
  input  wire [31:0] hwdata,      // write data
  output reg  [31:0] hrdata,      // read data, from flip-flop
  output wire        hreadyout,   // slave ready
  output wire        hresp,       // always okay
  input  wire [15:0] cpu_addr,    // local address from cpu or debug master
  output reg  [17:0] cpu_gaddr,   // registered global address
  output reg  [2:0]  cpu_region   // registered region code
);
`include "lgam_map.vh"

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  reg  [7:0]  program_page_select_r;      // program_page_select
  reg         ram4k_r;      // ram variant select
  reg  [15:0] xin_r;        // software local address to translate
  reg         wr_pend_r;    // a write data phase is pending
  reg  [9:0]  wr_addr_r;    // its byte address
  wire [7:0]  id_high;      // part id high byte
  wire [7:0]  id_low;       // part id low byte
  wire [17:0] x_gaddr;      // software translation result
  wire [17:0] c_gaddr;      // cpu translation result
  wire [2:0]  c_region;     // cpu region
  wire        acc;          // valid address phase
  reg  [31:0] rd_nxt;       // read data next value

  assign hreadyout = 1'b1;  // zero wait states
  assign hresp     = 1'b0;  // always okay, unmapped gives no error
  assign acc       = hsel & htrans[1] & hready;

  // ----------------------------------------------------------------------
  // sub blocks
  // ----------------------------------------------------------------------
  lgam_partid u_partid (
    .id_high (id_high),
    .id_low  (id_low)
  );

  lgam_xlate u_xsw (
    .local_addr  (xin_r),
    .program_page_select       (program_page_select_r),
    .ram_4k      (ram4k_r),
    .global_addr (x_gaddr),
    .region      ()
  );

  lgam_xlate u_xcpu (
    .local_addr  (cpu_addr),
    .program_page_select       (program_page_select_r),
    .ram_4k      (ram4k_r),
    .global_addr (c_gaddr),
    .region      (c_region)
  );

  // ----------------------------------------------------------------------
  // cpu side translation register
  // ----------------------------------------------------------------------
  always @(posedge core_clk) begin
    if (rst) begin
      cpu_gaddr  <= 18'h00000;
      cpu_region <= 3'h0;
    end else begin
      cpu_gaddr  <= c_gaddr;
      cpu_region <= c_region;
    end
  end

  // ----------------------------------------------------------------------
  // read decode
  // ----------------------------------------------------------------------
  always @* begin
    rd_nxt = 32'h00000000;  // reserved reads zero
    case (haddr[9:0])
      `LGAM_PROGRAM_PAGE_SELECT_OFS:     rd_nxt = {24'h000000, program_page_select_r};
      `LGAM_XLATE_IN_OFS:  rd_nxt = {16'h0000, xin_r};
      `LGAM_XLATE_OUT_OFS: rd_nxt = {14'h0000, x_gaddr};
      `LGAM_VERSION_OFS:   rd_nxt = {16'h0000, VERSION_ID};
      `LGAM_CFG_OFS:       rd_nxt = {31'h00000000, ram4k_r};
      `LGAM_PARTID_HI_OFS: rd_nxt = {24'h000000, id_high};
      `LGAM_PARTID_LO_OFS: rd_nxt = {24'h000000, id_low};
      default:             rd_nxt = 32'h00000000;
    endcase
    if (|haddr[31:10]) begin
      rd_nxt = 32'h00000000;
    end
  end

  // ----------------------------------------------------------------------
  // address phase capture and read data
  // ----------------------------------------------------------------------
  always @(posedge core_clk) begin
    if (rst) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 10'h000;
      hrdata    <= 32'h00000000;
    end else begin
      if (hready) begin
        wr_pend_r <= acc & hwrite & ~(|haddr[31:10]);
        wr_addr_r <= haddr[9:0];
      end
      if (acc & ~hwrite) begin
        hrdata <= rd_nxt;
      end
    end
  end

  // ----------------------------------------------------------------------
  // write data phase
  // ----------------------------------------------------------------------
  always @(posedge core_clk) begin
    if (rst) begin
      program_page_select_r <= `LGAM_PROGRAM_PAGE_SELECT_RST;
      ram4k_r <= `LGAM_CFG_RST;
      xin_r   <= 16'h0000;
    end else if (wr_pend_r) begin
      case (wr_addr_r)
        `LGAM_PROGRAM_PAGE_SELECT_OFS:    program_page_select_r <= hwdata[7:0];
        `LGAM_XLATE_IN_OFS: xin_r   <= hwdata[15:0];
        `LGAM_CFG_OFS:      ram4k_r <= hwdata[0];
        default: begin
          // part id, version and reserved writes are dropped
        end
      endcase
    end
  end

endmodule // lgam_top

/* File: verif/lgam_cpu_model.sv */
// cpu and debug master model that presents local addresses to the map
`timescale 1ns/10ps

module lgam_cpu_model (
  input  wire        core_clk,                  // bus clock
  input  wire [15:0] req_addr,                  // address the bench wants issued
  output logic [15:0] cpu_addr = 16'h0000       // local address bus, driven after the edge
);
  // the master launches each address one bus cycle after it is requested
  always @(posedge core_clk) begin
    cpu_addr <= req_addr;
  end
endmodule // lgam_cpu_model

/* File: verif/lgam_asserts.sv */
// concurrent checks on the ports of the address map block
`timescale 1ns/10ps

module lgam_asserts (
  input wire        core_clk,
  input wire        rst,
  input wire        hsel,
  input wire [31:0] haddr,
  input wire [1:0]  htrans,
  input wire        hwrite,
  input wire        hready,
  input wire [31:0] hrdata,
  input wire        hreadyout,
  input wire        hresp,
  input wire [15:0] cpu_addr,
  input wire [17:0] cpu_gaddr,
  input wire [2:0]  cpu_region
);
  // ----------------------------------------------------------------
  // checks, all in the bus clock domain
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  wire rd_take = hsel && htrans[1] && hready && !hwrite;  // read address phase taken

  df_map_a: assert property (cpu_addr inside {[16'h0400:16'h13ff]} |=> cpu_region == 3'd1
    && cpu_gaddr == {2'b00, $past(cpu_addr)} + 18'h04000) else $error("dflash map wrong");
  ram_map_a: assert property (cpu_addr inside {[16'h1400:16'h27ff]} |=> cpu_region == 3'd2
    && cpu_gaddr == {2'b11, $past(cpu_addr)}) else $error("ram map wrong");
  pf_low_a: assert property (cpu_addr inside {[16'h4000:16'h7fff]} |=> cpu_region == 3'd3
    && cpu_gaddr == {2'b11, $past(cpu_addr)}) else $error("low flash map wrong");
  pf_high_a: assert property (cpu_addr >= 16'hc000 |=> cpu_region == 3'd3
    && cpu_gaddr == {2'b11, $past(cpu_addr)}) else $error("high flash map wrong");
  win_offset_a: assert property (cpu_addr inside {[16'h8000:16'hbfff]} |=> cpu_region == 3'd4
    && ((cpu_gaddr ^ {2'b00, $past(cpu_addr)}) & 18'h03fff) == 18'h0) else $error("window wrong");
  dflt_map_a: assert property (cpu_addr < 16'h0400 |=> cpu_region == 3'd0
    && cpu_gaddr == {2'b11, $past(cpu_addr)}) else $error("default map wrong");
  rsv_zero_a: assert property (rd_take && haddr > 32'h3ff |=> hrdata == 32'h0)
    else $error("reserved read not zero");
  id_byte_a: assert property (rd_take && (haddr == 32'h68 || haddr == 32'h6c)
    |=> hrdata[31:8] == 24'h0) else $error("part id wider than a byte");
  bus_okay_a: assert property (!hresp && hreadyout) else $error("bus error or stall");

  cover property (cpu_region == 3'd4);
  cover property (cpu_region == 3'd2 && cpu_gaddr > 18'h327ff);
  cover property (hsel && htrans[1] && hwrite && haddr > 32'h3ff);
endmodule // lgam_asserts

bind lgam_top lgam_asserts i_lgam_asserts (.core_clk(core_clk), .rst(rst), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .cpu_addr(cpu_addr), .cpu_gaddr(cpu_gaddr),
  .cpu_region(cpu_region));

/* File: verif/tb_top.sv */
// self-checking bench for the local to global address map block
`timescale 1ns/10ps

module tb_top;
  logic        core_clk = 1'b0;   // 100 MHz bus clock
  logic        rst      = 1'b1;   // synchronous reset
  logic        hsel     = 1'b0;   // bus select
  logic [31:0] haddr    = 32'h0;  // bus address
  logic [1:0]  htrans   = 2'b00;  // transfer type
  logic        hwrite   = 1'b0;   // write strobe
  logic [31:0] hwdata   = 32'h0;  // write data
  logic [15:0] req_addr = 16'h0;  // address handed to the cpu model
  wire  [31:0] hrdata;            // read data
  wire         hreadyout;         // slave ready, also the bus ready
  wire         hresp;             // response
  wire  [15:0] cpu_addr;          // local address from the model
  wire  [17:0] cpu_gaddr;         // translated address
  wire  [2:0]  cpu_region;        // region code
  int          fails = 0;         // mismatches
  int          n_compared = 0;    // comparisons
  logic [31:0] rdv;               // last read value
  // local address, global address, region
  logic [36:0] tbl [11] = '{{16'h0000, 18'h30000, 3'd0}, {16'h03ff, 18'h303ff, 3'd0},
    {16'h0400, 18'h04400, 3'd1}, {16'h13ff, 18'h053ff, 3'd1}, {16'h1400, 18'h31400, 3'd2},
    {16'h27ff, 18'h327ff, 3'd2}, {16'h2800, 18'h32800, 3'd0}, {16'h4000, 18'h34000, 3'd3},
    {16'h7fff, 18'h37fff, 3'd3}, {16'hc000, 18'h3c000, 3'd3}, {16'hffff, 18'h3ffff, 3'd3}};

  lgam_top i_lgam_top (.core_clk(core_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hready(hreadyout), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .cpu_addr(cpu_addr),
    .cpu_gaddr(cpu_gaddr), .cpu_region(cpu_region));
  lgam_cpu_model i_lgam_cpu_model (.core_clk(core_clk), .req_addr(req_addr), .cpu_addr(cpu_addr));

  always #5 core_clk = ~core_clk;

  // ----------------------------------------------------------------
  // bus and compare helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one single word transfer, holding each phase until ready is seen
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge core_clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    rdv = hrdata;
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] exp);
    ahb(1'b0, a, 32'h0);
    chk(rdv, exp);
  endtask

  // model issues the address one edge later, the map answers one edge after that
  task automatic cpu(input logic [15:0] a, input logic [17:0] g, input logic [2:0] r);
    req_addr <= a;
    repeat (3) @(posedge core_clk);
    chk({14'h0, cpu_gaddr}, {14'h0, g});
    chk({29'h0, cpu_region}, {29'h0, r});
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_id();
    rd(32'h68, 32'h10);
    rd(32'h6c, 32'h81);
    rd(32'h0c, 32'h0);
    ahb(1'b1, 32'h68, 32'hff);
    ahb(1'b1, 32'h6c, 32'h0);
    rd(32'h68, 32'h10);
    rd(32'h6c, 32'h81);
  endtask

  task automatic t_rsv();
    ahb(1'b1, 32'h40, 32'hffffffff);
    ahb(1'b1, 32'h400, 32'h3);
    rd(32'h40, 32'h0);
    rd(32'h400, 32'h0);
    rd(32'h0, 32'h0f);
    rd(32'h4, 32'h0);
    rd(32'h10, 32'h0);
  endtask

  task automatic t_win();
    logic [15:0] a;
    for (int p = 0; p < 16; p++) begin
      a = (p == 15) ? 16'hbfff : 16'h8000 + 16'(p) * 16'h0123;
      ahb(1'b1, 32'h0, 32'(p));
      ahb(1'b1, 32'h4, {16'h0, a});
      rd(32'h8, {14'h0, 4'(p), a[13:0]});
      cpu(a, {4'(p), a[13:0]}, 3'd4);
    end
  endtask

  task automatic t_map();
    for (int i = 0; i < 11; i++) begin
      ahb(1'b1, 32'h4, {16'h0, tbl[i][36:21]});
      rd(32'h8, {14'h0, tbl[i][20:3]});
      cpu(tbl[i][36:21], tbl[i][20:3], tbl[i][2:0]);
    end
    ahb(1'b1, 32'h10, 32'h1);
    cpu(16'h2fff, 18'h32fff, 3'd2);
    ahb(1'b1, 32'h10, 32'h0);
    cpu(16'h2fff, 18'h32fff, 3'd0);
  endtask

  task automatic complete_run();
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    t_id();
    t_rsv();
    t_win();
    t_map();
    complete_run();
  end

  // watchdog: the run needs well under a thousand cycles
  initial begin
    #100000;
    fails++;
    complete_run();
  end
endmodule // tb_top
